// ---- test_windowed_watchdog_timer.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module test_windowed_watchdog_timer;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} wwdt_row_s;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [7:0]  option_byte = 8'hb1;
    logic        halt_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        interval_irq;
    logic        irq;
    logic        wdt_reset_req;
    logic [31:0] rd;
    logic [31:0] rd_a;
    int          n_fail = 0;
    int          check_count = 0;
    int          k;
    int          cyc = 0;
    int          t_hit;
    int          t_irq;
    wwdt_row_s   rows [5];

    // clock, cycle stamp, single slave drives the bus ready
    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    assign hready = hreadyout;

    wwdt_top #(.LS_DIV(4)) DUT (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .option_byte(option_byte),
        .halt_mode(halt_mode), .stop_mode(stop_mode), .interval_irq(interval_irq),
        .irq(irq), .wdt_reset_req(wdt_reset_req));

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic timed_out;
        n_fail++;
        $display("Error wait expected event seen timeout");
        test_done;
    endtask

    // master never assumes a latency, it polls ready with a bound
    task automatic edge_rdy;
        int i;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clock);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50)
            timed_out;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        edge_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy;
        rd = hrdata;
    endtask

    // option byte only changes while reset is held, as a strap would
    task automatic do_reset(input logic [7:0] opt);
        rstn <= 1'b0;
        option_byte <= opt;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    task automatic wait_cnt(input int th);
        for (k = 0; k < 300; k++)
        begin
            bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
            if (rd >= th) break;
        end
        if (k == 300)
            timed_out;
    endtask

    task automatic wait_hi(ref logic s, input int lim);
        for (k = 0; k < lim; k++)
        begin
            @(posedge clock);
            if (s === 1'b1) break;
        end
        if (k == lim)
            timed_out;
        t_hit = cyc;
    endtask

    initial
    begin
        rows[0] = '{1'b0, wwdt_pkg::SERVICE_OFS, 32'h0, 32'h9a};
        rows[1] = '{1'b1, wwdt_pkg::MASK_OFS, 32'hf, 32'hf};
        rows[2] = '{1'b1, wwdt_pkg::CONFIG_OFS, 32'hff, 32'hb1};
        rows[3] = '{1'b1, 8'h20, 32'h55, 32'h0};
        rows[4] = '{1'b1, wwdt_pkg::STATUS_OFS, 32'hf, 32'h0};
        do_reset(8'hb1);
        foreach (rows[i])
        begin
            if (rows[i].w)
                bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            `CHK("table read", rows[i].e, rd)
        end
        $display("register table done");
        // 50% window: first key early, then one open, then one closed
        do_reset(8'hb1);
        wait_cnt(20);
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        `CHK("first clear", 1'b1, rd < 8)
        `CHK("first no trip", 1'b0, wdt_reset_req)
        wait_cnt(34);
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        `CHK("open clear", 1'b1, rd < 8)
        `CHK("open no trip", 1'b0, wdt_reset_req)
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        repeat (3) @(posedge clock);
        `CHK("closed trip", 1'b1, wdt_reset_req)
        bus(1'b0, wwdt_pkg::STATUS_OFS, 32'h0);
        `CHK("window flag", 1'b1, rd[wwdt_pkg::ST_WINDOW])
        $display("window test done");
        // interval point, masking and clearing, then overflow 16 ticks after the interval point
        do_reset(8'hb1);
        bus(1'b1, wwdt_pkg::MASK_OFS, 32'h1);
        wait_hi(interval_irq, 600);
        t_irq = t_hit;
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        `CHK("interval point", 1'b1, rd >= 48 && rd <= 50)
        `CHK("irq raised", 1'b1, irq)
        bus(1'b1, wwdt_pkg::STATUS_OFS, 32'h1);
        repeat (2) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq)
        wait_hi(wdt_reset_req, 400);
        `CHK("overflow time", 1'b1, t_hit - t_irq >= 56 && t_hit - t_irq <= 72)
        bus(1'b0, wwdt_pkg::STATUS_OFS, 32'h0);
        `CHK("overflow flag", 1'b1, rd[wwdt_pkg::ST_OVERFLOW])
        `CHK("masked irq", 1'b0, irq)
        $display("interval and overflow test done");
        // wrong key, then a bit write, each from a fresh reset
        for (int j = 0; j < 2; j++)
        begin
            do_reset(8'hb1);
            bus(1'b1, j ? wwdt_pkg::BITOP_OFS : wwdt_pkg::SERVICE_OFS, j ? 32'hac : 32'h55);
            repeat (3) @(posedge clock);
            `CHK("bad write trip", 1'b1, wdt_reset_req)
            bus(1'b0, wwdt_pkg::STATUS_OFS, 32'h0);
            `CHK("bad key flag", 1'b1, rd[wwdt_pkg::ST_BADKEY])
        end
        $display("bad write test done");
        // standby select 0: full window, frozen in halt, cleared on wake
        do_reset(8'hb0);
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        repeat (3) @(posedge clock);
        `CHK("full window", 1'b0, wdt_reset_req)
        wait_cnt(10);
        halt_mode <= 1'b1;
        repeat (40) @(posedge clock);
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        rd_a = rd;
        repeat (20) @(posedge clock);
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        `CHK("halt freeze", rd_a, rd)
        halt_mode <= 1'b0;
        stop_mode <= 1'b1;
        repeat (20) @(posedge clock);
        stop_mode <= 1'b0;
        repeat (3) @(posedge clock);
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        `CHK("wake clear", 1'b1, rd < 4)
        // service soon after wake, well inside the overflow time
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        repeat (3) @(posedge clock);
        `CHK("wake service", 1'b0, wdt_reset_req)
        $display("standby test done");
        // counting disabled: other read-back, no trip on a wrong key
        do_reset(8'ha1);
        bus(1'b0, wwdt_pkg::SERVICE_OFS, 32'h0);
        `CHK("disabled read", 32'h1a, rd)
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'h55);
        repeat (3) @(posedge clock);
        `CHK("disabled no trip", 1'b0, wdt_reset_req)
        $display("disabled test done");
        // 75% window: first key early, then one after the interval flag, then one closed
        do_reset(8'hd1);
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        wait_hi(interval_irq, 600);
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        bus(1'b0, wwdt_pkg::COUNT_OFS, 32'h0);
        `CHK("late clear", 1'b1, rd < 8)
        `CHK("late no trip", 1'b0, wdt_reset_req)
        bus(1'b1, wwdt_pkg::SERVICE_OFS, 32'hac);
        repeat (3) @(posedge clock);
        `CHK("early trip", 1'b1, wdt_reset_req)
        $display("quarter window test done");
        test_done;
    end
endmodule // test_windowed_watchdog_timer

// ---- wwdt_core.sv ----
`timescale 1ns/1ps
module wwdt_core #(
    parameter int LS_DIV = wwdt_pkg::LS_DIV_CYC
) (
    // clock and reset
    input  wire logic  clock,
    input  wire logic  rstn,
    // control side
    wwdt_core_if.core  cif
);
    logic [wwdt_pkg::DIV_W-1:0] div_cnt;
    logic                       ls_tick;
    logic                       ls_mid;
    logic [wwdt_pkg::CNT_W-1:0] last;
    logic [wwdt_pkg::CNT_W-1:0] thr75;

    // low-speed clock as enables: full period and half-way point
    assign ls_tick = (div_cnt == wwdt_pkg::DIV_W'(LS_DIV - 1));
    assign ls_mid  = (div_cnt == wwdt_pkg::DIV_W'(LS_DIV / 2 - 1));
    // thresholds derived from the overflow exponent
    assign last  = wwdt_pkg::CNT_W'((18'h0_0001 << cif.exp) - 18'h0_0001);
    assign thr75 = wwdt_pkg::CNT_W'(3 * wwdt_pkg::quarter(cif.exp));

    // divider restarts with the counter so a clear gives a full period
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            div_cnt <= '0;
        else if (cif.clear || !cif.run || ls_tick)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // watchdog counter, advanced only on low-speed enables
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cif.count <= '0;
        else if (cif.clear)
            cif.count <= '0;
        else if (cif.run && ls_tick && cif.count != last)
            cif.count <= cif.count + 1'b1;
    end

    // one-cycle event pulses
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cif.overflow     <= 1'b0;
            cif.interval_hit <= 1'b0;
        end
        else
        begin
            cif.overflow     <= cif.run && !cif.clear && ls_tick && cif.count == last;
            cif.interval_hit <= cif.run && !cif.clear && ls_mid && cif.count == thr75;
        end
    end

    assign cif.window_open = (cif.count >= cif.win_thr);
endmodule // wwdt_core

// ---- wwdt_core_if.sv ----
`timescale 1ns/1ps
interface wwdt_core_if;
    logic                         run;
    logic                         clear;
    logic [4:0]                   exp;
    logic [wwdt_pkg::CNT_W-1:0]   win_thr;
    logic [wwdt_pkg::CNT_W-1:0]   count;
    logic                         overflow;
    logic                         interval_hit;
    logic                         window_open;

    modport ctrl (output run, clear, exp, win_thr,
                  input count, overflow, interval_hit, window_open);
    modport core (input run, clear, exp, win_thr,
                  output count, overflow, interval_hit, window_open);
endinterface

// ---- wwdt_pkg.sv ----
package wwdt_pkg;
    // register byte offsets
    localparam logic [7:0] SERVICE_OFS  = 8'h00;
    localparam logic [7:0] BITOP_OFS    = 8'h04;
    localparam logic [7:0] CONFIG_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS   = 8'h0c;
    localparam logic [7:0] MASK_OFS     = 8'h10;
    localparam logic [7:0] COUNT_OFS    = 8'h14;
    // option byte field positions
    localparam int IRQ_EN_BIT   = 7;
    localparam int WIN_HI_BIT   = 6;
    localparam int WIN_LO_BIT   = 5;
    localparam int CNT_EN_BIT   = 4;
    localparam int OVF_SEL_MSB  = 3;
    localparam int OVF_SEL_LSB  = 1;
    localparam int STBY_BIT     = 0;
    // status and mask bit positions
    localparam int ST_INTERVAL  = 0;
    localparam int ST_OVERFLOW  = 1;
    localparam int ST_WINDOW    = 2;
    localparam int ST_BADKEY    = 3;
    localparam int ST_WIDTH     = 4;
    // key and read-back values
    localparam logic [7:0] SERVICE_KEY  = 8'hac;
    localparam logic [7:0] READ_CNT_ON  = 8'h9a;
    localparam logic [7:0] READ_CNT_OFF = 8'h1a;
    // window selections
    localparam logic [1:0] WIN_PROHIB   = 2'h0;
    localparam logic [1:0] WIN_50       = 2'h1;
    localparam logic [1:0] WIN_75       = 2'h2;
    localparam logic [1:0] WIN_100      = 2'h3;
    // counter and timing
    localparam int CNT_W        = 17;
    localparam int DIV_W        = 16;
    localparam int SYS_CLK_HZ   = 100_000_000;
    localparam int LS_CLK_HZ    = 15_000;
    localparam int LS_DIV_CYC   = SYS_CLK_HZ / LS_CLK_HZ;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // overflow exponent from the three-bit select
    function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
        unique case (sel)
            3'h0: ovf_exp = 5'h06;
            3'h1: ovf_exp = 5'h07;
            3'h2: ovf_exp = 5'h08;
            3'h3: ovf_exp = 5'h09;
            3'h4: ovf_exp = 5'h0b;
            3'h5: ovf_exp = 5'h0d;
            3'h6: ovf_exp = 5'h0e;
            3'h7: ovf_exp = 5'h10;
        endcase
    endfunction

    // a quarter of the overflow period, in counts
    function automatic logic [CNT_W-1:0] quarter(input logic [4:0] e);
        quarter = CNT_W'(17'h1_0000 >> (5'h10 - e + 5'h02));
    endfunction
endpackage

// ---- wwdt_top.sv ----
`timescale 1ns/1ps
// overview of the datapath
// the option byte is a strap; it is caught once, at the first edge
// after reset release, and never again until the next reset.
// the core counts low-speed ticks made by a divider from the system
// clock; the divider restarts with every clear, so a clear always
// gives a whole tick before the next count.
//
// timing of the counter
// overflow comes when the counter sits at its last value and a tick
// arrives, so the overflow time is exactly a power of two in ticks.
// the interval event fires half a tick after the counter reaches
// three quarters of the overflow count.
// the window threshold is a counter value; the window is open once
// the counter has reached it.
//
// service path
// a service write is decoded in the bus data phase, when the write
// data stands; the clear and the reset request both come from that
// one decode, so a good and a bad write can never both act.
// the first service write after reset is let through whatever the
// window says; later ones must fall inside the open window.
//
// reset request
// any of overflow, closed-window write, wrong key or bit operation
// trips the block while counting is enabled.
// once tripped the request stays high and the counter stops; only
// the system reset that the request causes ends this state.
// with counting disabled the write events still land in status, so that
// software can see what would have happened.
//
// sleep handling
// with the standby select at zero the counter halts in either sleep
// mode and is cleared on wake, so the software gets a fresh period.
// moving from one sleep mode straight into the other is seen as one
// sleep, not as a wake.
//
// status and interrupt
// events set sticky status bits; software clears them by writing
// ones. an event in the same cycle as a clear wins, so no event is
// lost to a racing clear.
// the level interrupt looks at next status so that it follows a set
// or a clear without an extra cycle of lag.
// the interval pulse is a separate one-cycle output for a caller
// that wants an edge rather than a level.
//
// bus
// the slave never inserts wait states and always answers okay.
// read data is prepared from the address phase and registered, so it
// stands through the data phase and until the next read is taken.
// unmapped offsets read as zero and ignore writes.
//
// limitations
// the prohibited window code is treated as a full window, the
// reading that cannot trip a correct program.
// the counter saturates at its last value only as a guard; in normal
// use overflow trips the block before it matters.
// key writes while counting is disabled do not clear the counter.
// the low-speed divider assumes the system clock is far faster than
// the low-speed clock; small divider values are for simulation only.
module wwdt_top #(
    parameter int LS_DIV = wwdt_pkg::LS_DIV_CYC
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rstn,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    // option byte and power modes
    input  wire logic [7:0]   option_byte,
    input  wire logic         halt_mode,
    input  wire logic         stop_mode,
    // events out
    output logic              interval_irq,
    output logic              irq,
    output logic              wdt_reset_req
);
    typedef enum logic [1:0] {WWDT_LOAD, WWDT_RUN, WWDT_TRIPPED} wwdt_state_e;

    wwdt_core_if cif ();

    wwdt_state_e                state;
    logic [7:0]                 opt;
    logic                       first_done;
    logic                       was_asleep;
    logic [wwdt_pkg::ST_WIDTH-1:0] status;
    logic [wwdt_pkg::ST_WIDTH-1:0] mask;
    // data phase of the bus
    logic                       dp_write;
    logic [7:0]                 dp_addr;
    logic                       wr_service;
    logic                       wr_bitop;
    logic                       key_ok;
    logic                       in_window;
    logic                       asleep;
    logic                       cnt_on;
    logic                       stby_run;
    logic [1:0]                 win_sel;
    logic                       addr_phase;
    logic [wwdt_pkg::ST_WIDTH-1:0] ev;
    logic [wwdt_pkg::ST_WIDTH-1:0] w1c;
    logic [31:0]                next_rdata;
    logic                       bad_event;

    wwdt_core #(
        .LS_DIV (LS_DIV)
    ) u_core (
        .clock  (clock),
        .rstn   (rstn),
        .cif    (cif)
    );

    // option byte fields
    assign cnt_on   = opt[wwdt_pkg::CNT_EN_BIT];
    assign stby_run = opt[wwdt_pkg::STBY_BIT];
    assign win_sel  = {opt[wwdt_pkg::WIN_HI_BIT], opt[wwdt_pkg::WIN_LO_BIT]};
    assign asleep   = !stby_run && (halt_mode || stop_mode);

    // option byte is a strap, caught once after reset release
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            opt <= 8'h00;
        else if (state == WWDT_LOAD)
            opt <= option_byte;
    end

    // load, run, and hold after tripping until system reset
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state <= WWDT_LOAD;
        else
        begin
            unique case (state)
                WWDT_LOAD:    state <= WWDT_RUN;
                WWDT_RUN:     if (bad_event) state <= WWDT_TRIPPED;
                WWDT_TRIPPED: state <= WWDT_TRIPPED;
            endcase
        end
    end

    // window start point from selection; standby off means full window
    always_comb
    begin
        cif.exp = wwdt_pkg::ovf_exp(opt[wwdt_pkg::OVF_SEL_MSB:wwdt_pkg::OVF_SEL_LSB]);
        if (!stby_run)
            cif.win_thr = '0;
        else
        begin
            unique case (win_sel)
                wwdt_pkg::WIN_50:  cif.win_thr = wwdt_pkg::CNT_W'(2 * wwdt_pkg::quarter(cif.exp));
                wwdt_pkg::WIN_75:  cif.win_thr = wwdt_pkg::quarter(cif.exp);
                // prohibited code treated as full window, the safest reading
                wwdt_pkg::WIN_100,
                wwdt_pkg::WIN_PROHIB: cif.win_thr = '0;
            endcase
        end
    end

    // counter runs only when enabled, configured and not halted by a sleep mode
    assign cif.run   = cnt_on && (state == WWDT_RUN) && !asleep;
    assign in_window = cif.window_open || !first_done;

    // ahb address phase capture
    assign addr_phase = hsel && htrans[1] && hready;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end
        else
        begin
            dp_write <= addr_phase && hwrite;
            dp_addr  <= haddr[7:0];
        end
    end

    // write decode in data phase
    assign wr_service = dp_write && dp_addr == wwdt_pkg::SERVICE_OFS;
    assign wr_bitop   = dp_write && dp_addr == wwdt_pkg::BITOP_OFS;
    assign key_ok     = hwdata[7:0] == wwdt_pkg::SERVICE_KEY;

    // clear on good service, and on wake from a halted sleep
    assign cif.clear = (wr_service && key_ok && in_window && cnt_on)
                     || (was_asleep && !asleep);

    // track sleep so wake can restart from zero
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            was_asleep <= 1'b0;
        else
            was_asleep <= asleep;
    end

    // first service write after reset lifts the window rule once
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            first_done <= 1'b0;
        else if (wr_service && state == WWDT_RUN)
            first_done <= 1'b1;
    end

    // event vector feeding sticky status
    always_comb
    begin
        ev = '0;
        ev[wwdt_pkg::ST_INTERVAL] = cif.interval_hit && opt[wwdt_pkg::IRQ_EN_BIT];
        ev[wwdt_pkg::ST_OVERFLOW] = cif.overflow;
        ev[wwdt_pkg::ST_WINDOW]   = wr_service && key_ok && !in_window;
        ev[wwdt_pkg::ST_BADKEY]   = (wr_service && !key_ok) || wr_bitop;
    end

    // a disabled counter never trips the reset
    assign bad_event = cnt_on && (ev[wwdt_pkg::ST_OVERFLOW] || ev[wwdt_pkg::ST_WINDOW]
                     || ev[wwdt_pkg::ST_BADKEY]);

    // write-one-to-clear request for status
    assign w1c = (dp_write && dp_addr == wwdt_pkg::STATUS_OFS)
               ? hwdata[wwdt_pkg::ST_WIDTH-1:0] : '0;

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            status <= '0;
        else
            status <= (status & ~w1c) | ev;
    end

    // interrupt mask, one bit per status bit
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            mask <= '0;
        else if (dp_write && dp_addr == wwdt_pkg::MASK_OFS)
            mask <= hwdata[wwdt_pkg::ST_WIDTH-1:0];
    end

    // registered event outputs
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            interval_irq  <= 1'b0;
            irq           <= 1'b0;
            wdt_reset_req <= 1'b0;
        end
        else
        begin
            interval_irq <= ev[wwdt_pkg::ST_INTERVAL];
            irq          <= |(((status & ~w1c) | ev) & mask);
            // held until the system reset this request causes
            if (bad_event && state == WWDT_RUN)
                wdt_reset_req <= 1'b1;
        end
    end

    // read mux, prepared during the address phase
    always_comb
    begin
        next_rdata = wwdt_pkg::RDATA_RST;
        unique case (haddr[7:0])
            wwdt_pkg::SERVICE_OFS:
                next_rdata[7:0] = cnt_on ? wwdt_pkg::READ_CNT_ON : wwdt_pkg::READ_CNT_OFF;
            wwdt_pkg::CONFIG_OFS:
                next_rdata[7:0] = opt;
            wwdt_pkg::STATUS_OFS:
                next_rdata[wwdt_pkg::ST_WIDTH-1:0] = status;
            wwdt_pkg::MASK_OFS:
                next_rdata[wwdt_pkg::ST_WIDTH-1:0] = mask;
            wwdt_pkg::COUNT_OFS:
                next_rdata[wwdt_pkg::CNT_W-1:0] = cif.count;
            default:
                next_rdata = wwdt_pkg::RDATA_RST;
        endcase
    end

    // zero-wait slave, always okay; unmapped reads give zero
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            hrdata    <= wwdt_pkg::RDATA_RST;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_phase && !hwrite)
                hrdata <= next_rdata;
        end
    end
endmodule // wwdt_top

// ---- wwdt_top_sva.sv ----
`timescale 1ns/1ps
module wwdt_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // bus side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // strap and events
    input wire logic [7:0]  option_byte,
    input wire logic        interval_irq,
    input wire logic        wdt_reset_req
);
    logic       take;
    logic [1:0] wr_ph;
    logic       rd_svc;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // remember the address phase into the data phase, where hwdata and hrdata stand
    assign take = hsel & htrans[1] & hready;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ph  <= 2'h0;
            rd_svc <= 1'b0;
        end
        else
        begin
            wr_ph  <= {take & hwrite & (haddr[7:0] == wwdt_pkg::BITOP_OFS),
                       take & hwrite & (haddr[7:0] == wwdt_pkg::SERVICE_OFS)};
            rd_svc <= take & !hwrite & (haddr[7:0] == wwdt_pkg::SERVICE_OFS);
        end
    end
    // zero-wait slave, never an error response
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus wait or error response seen");
    property p_svc_read; rd_svc |-> hrdata == {24'h0, option_byte[4] ?
        wwdt_pkg::READ_CNT_ON : wwdt_pkg::READ_CNT_OFF}; endproperty
    a_svc_read: assert property (p_svc_read) else $error("service read-back wrong");
    property p_bad_key; wr_ph[0] && hwdata[7:0] != wwdt_pkg::SERVICE_KEY && option_byte[4]
        |-> ##[1:3] wdt_reset_req; endproperty
    a_bad_key: assert property (p_bad_key) else $error("wrong key did not trip");
    property p_bitop; wr_ph[1] && option_byte[4] |-> ##[1:3] wdt_reset_req; endproperty
    a_bitop: assert property (p_bitop) else $error("bit write did not trip");
    // a trip stays until the next reset
    property p_hold; wdt_reset_req |=> wdt_reset_req; endproperty
    a_hold: assert property (p_hold) else $error("reset request dropped");
    property p_off; !option_byte[4] |-> !wdt_reset_req; endproperty
    a_off: assert property (p_off) else $error("trip while counting disabled");
    property p_pulse; interval_irq |=> !interval_irq; endproperty
    a_pulse: assert property (p_pulse) else $error("interval pulse too long");
    property p_irq_en; interval_irq |-> option_byte[7]; endproperty
    a_irq_en: assert property (p_irq_en) else $error("interval pulse while disabled");
endmodule // wwdt_chk

bind wwdt_top wwdt_chk u_chk (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .option_byte(option_byte),
    .interval_irq(interval_irq), .wdt_reset_req(wdt_reset_req));
